// File: pkg/rtrb_pkg.sv
// Shared constants and types of the radio tuning register bank
package rtrb_pkg;

    // ==========================================================
    // Register access widths and offsets
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFS_STRENGTH   = 6'h22;
    localparam logic [ADDR_W-1:0] OFS_TX_GAIN    = 6'h23;
    localparam logic [ADDR_W-1:0] OFS_XTAL_CLK   = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_OSC_SLOPE  = 6'h26;
    localparam logic [ADDR_W-1:0] OFS_PWR_SAVE   = 6'h2e;
    localparam logic [ADDR_W-1:0] OFS_CD_OVR     = 6'h2f;
    localparam logic [ADDR_W-1:0] OFS_MCLK_OVR   = 6'h32;
    localparam logic [ADDR_W-1:0] OFS_MCLK_GATE  = 6'h33;
    localparam logic [ADDR_W-1:0] OFS_LOCK_DELAY = 6'h38;

    // ==========================================================
    // Field positions
    localparam int STR_VALID_BIT = 5;
    localparam int STR_VALUE_W   = 5;
    localparam int GAIN_W        = 3;
    localparam int CLKOUT_DIS    = 6;
    localparam int TRIM_W        = 6;
    localparam int SLOPE_LSB     = 6;
    localparam int PWR_SAVE_BIT  = 7;
    localparam int CD_OVR_BIT    = 7;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] RST_ZERO       = 8'h00;
    localparam logic [DATA_W-1:0] RST_LOCK_DELAY = 8'h64;
    localparam logic [DATA_W-1:0] RD_UNMAPPED    = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int LOCK_STEP_NS  = 2000;
    localparam int LOCK_STEP_CYC = (LOCK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SLOPE_NONE   = 2'h0,
        SLOPE_RSVD   = 2'h1,
        SLOPE_NARROW = 2'h2,
        SLOPE_WIDE   = 2'h3
    } rtrb_slope_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rtrb_req_s;

    typedef struct packed {
        logic                   valid;
        logic [STR_VALUE_W-1:0] value;
    } rtrb_strength_s;

endpackage

// File: design/rtrb_strength_capture.sv
// One-shot received strength capture per receive-mode entry
`timescale 1ns/100ps
module rtrb_strength_capture
    import rtrb_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic                   rx_enable,
    input  wire logic                   sample_ready,
    input  wire logic [STR_VALUE_W-1:0] sample_value,
    output rtrb_strength_s              strength
);

    logic           rx_q;
    logic           armed;
    logic           next_rx_q;
    logic           next_armed;
    rtrb_strength_s next_strength;

    always_comb begin
        next_rx_q     = rx_enable;
        next_armed    = armed;
        next_strength = strength;
        if (rx_enable && !rx_q) begin
            next_armed          = 1'b1;
            next_strength.valid = 1'b0;
        end else if (armed && sample_ready) begin
            next_armed          = 1'b0;
            next_strength.valid = 1'b1;
            next_strength.value = sample_value;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q     <= 1'b0;
            armed    <= 1'b0;
            strength <= '0;
        end else if (ce) begin
            rx_q     <= next_rx_q;
            armed    <= next_armed;
            strength <= next_strength;
        end
    end

endmodule

// File: design/rtrb_lock_timer.sv
// Synthesizer lock delay timer in fixed time steps
`timescale 1ns/100ps
module rtrb_lock_timer
    import rtrb_pkg::*;
#(
    parameter int STEP_CYC = LOCK_STEP_CYC
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              start,
    input  wire logic [DATA_W-1:0] count,
    output logic                   locked
);

    localparam int SW = $clog2(STEP_CYC + 1);
    localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);

    typedef enum logic [1:0] {IDLE, WAIT, DONE} rtrb_lock_e;

    rtrb_lock_e        state;
    rtrb_lock_e        next_state;
    logic [SW-1:0]     step;
    logic [SW-1:0]     next_step;
    logic [DATA_W-1:0] left;
    logic [DATA_W-1:0] next_left;

    always_comb begin
        next_state = state;
        next_step  = step;
        next_left  = left;
        case (state)
            IDLE, DONE: begin
                if (start) begin
                    next_step  = '0;
                    next_left  = count;
                    next_state = (count == '0) ? DONE : WAIT;
                end
            end
            WAIT: begin
                if (start) begin
                    next_step = '0;
                    next_left = count;
                    if (count == '0)
                        next_state = DONE;
                end else if (step == STEP_LAST) begin
                    next_step = '0;
                    next_left = left - 1'b1;
                    if (left == 8'h01)
                        next_state = DONE;
                end else begin
                    next_step = step + 1'b1;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            step  <= '0;
            left  <= '0;
        end else if (ce) begin
            state <= next_state;
            step  <= next_step;
            left  <= next_left;
        end
    end

    assign locked = (state == DONE);

endmodule

// File: design/rtrb_top.sv
// Radio tuning register bank: storage, gating, readback and outputs
// ==========================================================
// Functional notes
// - Strength register bit 5 reads 1 when the strength value is valid.
// - Strength low five bits give unsigned strength, larger means stronger.
// - One new strength sample is captured per entry into receive mode.
// - Three-bit transmit gain 0..7, higher setting gives more power.
// - Reference clock driven while disable bit is 0; resets enabled.
// - Six-bit crystal load trim, each step adds fixed load capacitance.
// - Slope 11 widest, 10 narrower, 00 none, 01 reserved.
// - Slope register is write-only; its read bits are undefined.
// - Power-saving writes only land while the write gate is open.
// - Override bit set forces carrier detect, ignoring internal result.
// - Carrier override writes only land while the write gate is open.
// - Power-saving and override registers are read-only with gate closed.
// - Auto synth without lock pin waits count times fixed step.
`timescale 1ns/100ps
module rtrb_top
    import rtrb_pkg::*;
#(
    parameter int STEP_CYC = LOCK_STEP_CYC
)(
    input  wire logic                   MCLK,
    input  wire logic                   NRST,
    input  wire logic                   CLK_EN,
    input  wire rtrb_req_s              REG_REQ,
    output logic [DATA_W-1:0]           REG_RDATA,
    input  wire logic                   WRITE_GATE,
    input  wire logic                   RX_ENABLE,
    input  wire logic                   STRENGTH_READY,
    input  wire logic [STR_VALUE_W-1:0] STRENGTH_IN,
    input  wire logic                   CARRIER_DETECT_IN,
    output logic                        CARRIER_DETECT,
    input  wire logic                   AUTO_SYNTH,
    input  wire logic                   USE_LOCK_PIN,
    input  wire logic                   SYNTH_START,
    input  wire logic                   PLL_LOCK,
    output logic                        SYNTH_LOCKED,
    output logic [GAIN_W-1:0]           TX_GAIN,
    output logic [TRIM_W-1:0]           XTAL_TRIM,
    output logic                        OSC_ADJ_WIDE,
    output logic                        OSC_ADJ_NARROW,
    output logic                        POWER_SAVE,
    output logic [DATA_W-1:0]           MCLK_OVERRIDE,
    output logic [DATA_W-1:0]           MCLK_GATE,
    output logic                        REF_CLK_OUT,
    output logic                        REF_CLK_OE_N
);

    // ==========================================================
    // Decode helpers
    function automatic logic hit(input rtrb_req_s r, input logic [ADDR_W-1:0] ofs);
        hit = (r.addr == ofs);
    endfunction

    function automatic logic slope_is(input logic [1:0] f, input rtrb_slope_e s);
        slope_is = (f == s);
    endfunction

    // ==========================================================
    // Synchronisers for analog-side inputs
    localparam int SYN_W = STR_VALUE_W + 3;

    logic [SYN_W-1:0] sync1;
    logic [SYN_W-1:0] sync2;

    logic                   ready_s;
    logic [STR_VALUE_W-1:0] value_s;
    logic                   cd_s;
    logic                   pll_s;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (CLK_EN) begin
            sync1 <= {STRENGTH_READY, STRENGTH_IN, CARRIER_DETECT_IN, PLL_LOCK};
            sync2 <= sync1;
        end
    end

    assign {ready_s, value_s, cd_s, pll_s} = sync2;

    // ==========================================================
    // Writable registers
    logic [GAIN_W-1:0] gain;
    logic [TRIM_W-1:0] trim;
    logic              clkout_dis;
    logic [1:0]        slope;
    logic              psave;
    logic              cd_ovr;
    logic [DATA_W-1:0] mclk_ovr;
    logic [DATA_W-1:0] mclk_gate;
    logic [DATA_W-1:0] lock_delay;

    logic [GAIN_W-1:0] next_gain;
    logic [TRIM_W-1:0] next_trim;
    logic              next_clkout_dis;
    logic [1:0]        next_slope;
    logic              next_psave;
    logic              next_cd_ovr;
    logic [DATA_W-1:0] next_mclk_ovr;
    logic [DATA_W-1:0] next_mclk_gate;
    logic [DATA_W-1:0] next_lock_delay;

    always_comb begin
        next_gain       = gain;
        next_trim       = trim;
        next_clkout_dis = clkout_dis;
        next_slope      = slope;
        next_psave      = psave;
        next_cd_ovr     = cd_ovr;
        next_mclk_ovr   = mclk_ovr;
        next_mclk_gate  = mclk_gate;
        next_lock_delay = lock_delay;
        if (REG_REQ.wr) begin
            if (hit(REG_REQ, OFS_TX_GAIN))
                next_gain = REG_REQ.wdata[GAIN_W-1:0];
            if (hit(REG_REQ, OFS_XTAL_CLK)) begin
                next_trim       = REG_REQ.wdata[TRIM_W-1:0];
                next_clkout_dis = REG_REQ.wdata[CLKOUT_DIS];
            end
            if (hit(REG_REQ, OFS_OSC_SLOPE))
                next_slope = REG_REQ.wdata[SLOPE_LSB+1:SLOPE_LSB];
            if (hit(REG_REQ, OFS_PWR_SAVE) && WRITE_GATE)
                next_psave = REG_REQ.wdata[PWR_SAVE_BIT];
            if (hit(REG_REQ, OFS_CD_OVR) && WRITE_GATE)
                next_cd_ovr = REG_REQ.wdata[CD_OVR_BIT];
            if (hit(REG_REQ, OFS_MCLK_OVR))
                next_mclk_ovr = REG_REQ.wdata;
            if (hit(REG_REQ, OFS_MCLK_GATE))
                next_mclk_gate = REG_REQ.wdata;
            if (hit(REG_REQ, OFS_LOCK_DELAY))
                next_lock_delay = REG_REQ.wdata;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            gain       <= RST_ZERO[GAIN_W-1:0];
            trim       <= RST_ZERO[TRIM_W-1:0];
            clkout_dis <= RST_ZERO[CLKOUT_DIS];
            slope      <= RST_ZERO[SLOPE_LSB+1:SLOPE_LSB];
            psave      <= RST_ZERO[PWR_SAVE_BIT];
            cd_ovr     <= RST_ZERO[CD_OVR_BIT];
            mclk_ovr   <= RST_ZERO;
            mclk_gate  <= RST_ZERO;
            lock_delay <= RST_LOCK_DELAY;
        end else if (CLK_EN) begin
            gain       <= next_gain;
            trim       <= next_trim;
            clkout_dis <= next_clkout_dis;
            slope      <= next_slope;
            psave      <= next_psave;
            cd_ovr     <= next_cd_ovr;
            mclk_ovr   <= next_mclk_ovr;
            mclk_gate  <= next_mclk_gate;
            lock_delay <= next_lock_delay;
        end
    end

    // ==========================================================
    // Received strength capture
    rtrb_strength_s strength;

    rtrb_strength_capture u_capture (
        .clk          (MCLK),
        .rst_n        (NRST),
        .ce           (CLK_EN),
        .rx_enable    (RX_ENABLE),
        .sample_ready (ready_s),
        .sample_value (value_s),
        .strength     (strength)
    );

    // ==========================================================
    // Synthesizer lock timing
    logic timer_locked;
    logic timer_start;

    assign timer_start = SYNTH_START && AUTO_SYNTH && !USE_LOCK_PIN;

    rtrb_lock_timer #(
        .STEP_CYC (STEP_CYC)
    ) u_lock (
        .clk    (MCLK),
        .rst_n  (NRST),
        .ce     (CLK_EN),
        .start  (timer_start),
        .count  (lock_delay),
        .locked (timer_locked)
    );

    // ==========================================================
    // Readback
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        rd_word = RD_UNMAPPED;
        case (REG_REQ.addr)
            OFS_STRENGTH: begin
                rd_word[STR_VALID_BIT]     = strength.valid;
                rd_word[STR_VALUE_W-1:0]   = strength.value;
            end
            OFS_TX_GAIN:    rd_word[GAIN_W-1:0] = gain;
            OFS_XTAL_CLK: begin
                rd_word[TRIM_W-1:0] = trim;
                rd_word[CLKOUT_DIS] = clkout_dis;
            end
            OFS_OSC_SLOPE:  rd_word = RD_UNMAPPED;
            OFS_PWR_SAVE:   rd_word[PWR_SAVE_BIT] = psave;
            OFS_CD_OVR:     rd_word[CD_OVR_BIT] = cd_ovr;
            OFS_MCLK_OVR:   rd_word = mclk_ovr;
            OFS_MCLK_GATE:  rd_word = mclk_gate;
            OFS_LOCK_DELAY: rd_word = lock_delay;
            default:        rd_word = RD_UNMAPPED;
        endcase
        next_rdata = REG_REQ.rd ? rd_word : REG_RDATA;
    end

    // ==========================================================
    // Analog-facing outputs
    logic next_wide;
    logic next_narrow;
    logic next_cd;
    logic next_locked;
    logic ref_div;
    logic next_ref_div;
    logic next_ref_out;

    always_comb begin
        next_wide    = slope_is(slope, SLOPE_WIDE);
        next_narrow  = slope_is(slope, SLOPE_NARROW);
        next_cd      = cd_ovr ? 1'b1 : cd_s;
        if (AUTO_SYNTH && !USE_LOCK_PIN)
            next_locked = timer_locked;
        else
            next_locked = pll_s;
        next_ref_div = ~ref_div;
        next_ref_out = clkout_dis ? 1'b0 : next_ref_div;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA      <= RD_UNMAPPED;
            OSC_ADJ_WIDE   <= 1'b0;
            OSC_ADJ_NARROW <= 1'b0;
            CARRIER_DETECT <= 1'b0;
            SYNTH_LOCKED   <= 1'b0;
            ref_div        <= 1'b0;
            REF_CLK_OUT    <= 1'b0;
            REF_CLK_OE_N   <= 1'b0;
        end else if (CLK_EN) begin
            REG_RDATA      <= next_rdata;
            OSC_ADJ_WIDE   <= next_wide;
            OSC_ADJ_NARROW <= next_narrow;
            CARRIER_DETECT <= next_cd;
            SYNTH_LOCKED   <= next_locked;
            ref_div        <= next_ref_div;
            REF_CLK_OUT    <= next_ref_out;
            REF_CLK_OE_N   <= clkout_dis;
        end
    end

    // Register copies straight to the analog side
    assign TX_GAIN       = gain;
    assign XTAL_TRIM     = trim;
    assign POWER_SAVE    = psave;
    assign MCLK_OVERRIDE = mclk_ovr;
    assign MCLK_GATE     = mclk_gate;

endmodule

// File: testbench/rtrb_chk.sv
// Port-level assertions for the radio tuning register bank
`timescale 1ns/100ps
module rtrb_chk
    import rtrb_pkg::*;
#(
    parameter int STEP_CYC = LOCK_STEP_CYC
)(
    input wire logic              MCLK,
    input wire logic              NRST,
    input wire logic              CLK_EN,
    input wire rtrb_req_s         REG_REQ,
    input wire logic              WRITE_GATE,
    input wire logic              AUTO_SYNTH,
    input wire logic              USE_LOCK_PIN,
    input wire logic              PLL_LOCK,
    input wire logic              SYNTH_LOCKED,
    input wire logic [GAIN_W-1:0] TX_GAIN,
    input wire logic [TRIM_W-1:0] XTAL_TRIM,
    input wire logic              OSC_ADJ_WIDE,
    input wire logic              OSC_ADJ_NARROW,
    input wire logic              POWER_SAVE,
    input wire logic              CARRIER_DETECT,
    input wire logic              REF_CLK_OUT,
    input wire logic              REF_CLK_OE_N
);
    logic wr_ok;
    assign wr_ok = REG_REQ.wr && CLK_EN;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // ==========================================================
    // Register writes and gating
    property p_gain;
        wr_ok && REG_REQ.addr == OFS_TX_GAIN |=> TX_GAIN == $past(REG_REQ.wdata[2:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain not loaded");
    property p_trim;
        wr_ok && REG_REQ.addr == OFS_XTAL_CLK |=> XTAL_TRIM == $past(REG_REQ.wdata[5:0]);
    endproperty
    a_trim: assert property (p_trim) else $error("trim not loaded");
    property p_pwr_wr;
        wr_ok && REG_REQ.addr == OFS_PWR_SAVE && WRITE_GATE
            |=> POWER_SAVE == $past(REG_REQ.wdata[7]);
    endproperty
    a_pwr_wr: assert property (p_pwr_wr) else $error("gated write lost");
    property p_pwr_ro;
        wr_ok && REG_REQ.addr == OFS_PWR_SAVE && !WRITE_GATE |=> $stable(POWER_SAVE);
    endproperty
    a_pwr_ro: assert property (p_pwr_ro) else $error("closed gate write landed");
    property p_cd;
        wr_ok && REG_REQ.addr == OFS_CD_OVR && WRITE_GATE && REG_REQ.wdata[7]
            |-> ##2 CARRIER_DETECT;
    endproperty
    a_cd: assert property (p_cd) else $error("override not forcing detect");
    property p_slope;
        wr_ok && REG_REQ.addr == OFS_OSC_SLOPE |-> ##2
            OSC_ADJ_WIDE == ($past(REG_REQ.wdata[7:6], 2) == 2'h3) &&
            OSC_ADJ_NARROW == ($past(REG_REQ.wdata[7:6], 2) == 2'h2);
    endproperty
    a_slope: assert property (p_slope) else $error("slope decode wrong");
    // ==========================================================
    // Reference clock and lock
    property p_oe;
        wr_ok && REG_REQ.addr == OFS_XTAL_CLK |-> ##2 REF_CLK_OE_N == $past(REG_REQ.wdata[6], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("clock enable wrong");
    property p_ref_off;
        REF_CLK_OE_N && $past(REF_CLK_OE_N) |-> !REF_CLK_OUT;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("clock runs while off");
    property p_ref_run;
        (!REF_CLK_OE_N && CLK_EN) [*2] |-> REF_CLK_OUT != $past(REF_CLK_OUT);
    endproperty
    a_ref_run: assert property (p_ref_run) else $error("clock not toggling");
    property p_pin;
        ((!AUTO_SYNTH || USE_LOCK_PIN) && PLL_LOCK) [*4] |-> SYNTH_LOCKED;
    endproperty
    a_pin: assert property (p_pin) else $error("lock pin not followed");
    c_gate_wr: cover property (wr_ok && REG_REQ.addr == OFS_PWR_SAVE && WRITE_GATE);
    c_wide: cover property (OSC_ADJ_WIDE);
    c_lock: cover property ($rose(SYNTH_LOCKED) && AUTO_SYNTH && !USE_LOCK_PIN);
endmodule

bind rtrb_top rtrb_chk #(.STEP_CYC(STEP_CYC)) i_chk (
    .MCLK(MCLK), .NRST(NRST), .CLK_EN(CLK_EN), .REG_REQ(REG_REQ),
    .WRITE_GATE(WRITE_GATE), .AUTO_SYNTH(AUTO_SYNTH), .USE_LOCK_PIN(USE_LOCK_PIN),
    .PLL_LOCK(PLL_LOCK), .SYNTH_LOCKED(SYNTH_LOCKED), .TX_GAIN(TX_GAIN),
    .XTAL_TRIM(XTAL_TRIM), .OSC_ADJ_WIDE(OSC_ADJ_WIDE), .OSC_ADJ_NARROW(OSC_ADJ_NARROW),
    .POWER_SAVE(POWER_SAVE), .CARRIER_DETECT(CARRIER_DETECT),
    .REF_CLK_OUT(REF_CLK_OUT), .REF_CLK_OE_N(REF_CLK_OE_N)
);

// File: testbench/rtrb_host.sv
// Host model that reaches the register bank over its access port
`timescale 1ns/100ps
module rtrb_host
    import rtrb_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [DATA_W-1:0] rdata,
    output rtrb_req_s              req,
    output logic                   gate
);
    initial begin
        req = '0;
        gate = 1'b0;
    end
    // ==========================================================
    // Accesses, held from one falling edge to the next
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge mclk);
        req <= '{1'b1, 1'b0, a, d};
        @(negedge mclk);
        req <= '0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge mclk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk);
        req <= '0;
        @(negedge mclk);
        d = rdata;
    endtask
    task automatic set_gate(input logic g);
        @(negedge mclk);
        gate <= g;
    endtask
    // ==========================================================
    // Start-up sequence, reserved bits always zero
    task automatic init();
        wr(OFS_MCLK_OVR, 8'h41);
        wr(OFS_MCLK_GATE, 8'h41);
        wr(OFS_OSC_SLOPE, 8'hc0);
        wr(OFS_TX_GAIN, 8'h07);
        wr(OFS_XTAL_CLK, 8'h40);
        set_gate(1'b1);
        wr(OFS_PWR_SAVE, 8'h80);
        set_gate(1'b0);
    endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking testbench of the radio tuning register bank
`timescale 1ns/100ps
module tb_top;
    import rtrb_pkg::*;
    logic              mclk = 1'b0;
    logic              nrst = 1'b0;
    logic              clk_en = 1'b1;
    logic              rx_en = 1'b0;
    logic              rdy = 1'b0;
    logic [4:0]        s_in = '0;
    logic              cd_in = 1'b0;
    logic              auto_syn = 1'b0;
    logic              use_pin = 1'b0;
    logic              start = 1'b0;
    logic              pll = 1'b0;
    rtrb_req_s         req;
    logic              gate;
    logic [DATA_W-1:0] rdata, rv, mco, mcg;
    logic              cd, locked, ow, on, ps, rco, roe;
    logic [GAIN_W-1:0] gain;
    logic [TRIM_W-1:0] trim;
    logic [5:0]        ofs [8] = '{OFS_STRENGTH, OFS_TX_GAIN, OFS_XTAL_CLK, OFS_OSC_SLOPE,
                                   OFS_PWR_SAVE, OFS_CD_OVR, OFS_MCLK_OVR, 6'h10};
    int                error_cnt = 0;
    int                checked = 0;
    always #20 mclk = ~mclk;
    rtrb_host i_host (.mclk(mclk), .rdata(rdata), .req(req), .gate(gate));
    rtrb_top #(.STEP_CYC(2)) i_dut (
        .MCLK(mclk), .NRST(nrst), .CLK_EN(clk_en), .REG_REQ(req), .REG_RDATA(rdata),
        .WRITE_GATE(gate), .RX_ENABLE(rx_en), .STRENGTH_READY(rdy), .STRENGTH_IN(s_in),
        .CARRIER_DETECT_IN(cd_in), .CARRIER_DETECT(cd), .AUTO_SYNTH(auto_syn),
        .USE_LOCK_PIN(use_pin), .SYNTH_START(start), .PLL_LOCK(pll), .SYNTH_LOCKED(locked),
        .TX_GAIN(gain), .XTAL_TRIM(trim), .OSC_ADJ_WIDE(ow), .OSC_ADJ_NARROW(on),
        .POWER_SAVE(ps), .MCLK_OVERRIDE(mco), .MCLK_GATE(mcg), .REF_CLK_OUT(rco),
        .REF_CLK_OE_N(roe)
    );
    task automatic test_done();
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rc(input logic [5:0] a, input logic [7:0] exp);
        i_host.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Whole sequence needs under 1500 cycles
    initial begin
        #(5000 * 40);
        error_cnt++;
        test_done();
    end
    initial begin
        cyc(12);
        nrst = 1'b1;
        for (int i = 0; i < 8; i++) rc(ofs[i], RST_ZERO);
        rc(OFS_LOCK_DELAY, RST_LOCK_DELAY);
        chk(roe, 1'b0);
        i_host.init();
        chk(mco, 8'h41);
        chk(mcg, 8'h41);
        chk(ps, 1'b1);
        chk(roe, 1'b1);
        chk(rco, 1'b0);
        rc(OFS_OSC_SLOPE, RD_UNMAPPED);
        // Gate closed: both guarded registers refuse
        i_host.wr(OFS_PWR_SAVE, 8'h00);
        rc(OFS_PWR_SAVE, 8'h80);
        i_host.wr(OFS_CD_OVR, 8'h80);
        rc(OFS_CD_OVR, 8'h00);
        chk(cd, 1'b0);
        i_host.set_gate(1'b1);
        i_host.wr(OFS_CD_OVR, 8'h80);
        chk(cd, 1'b1);
        i_host.wr(OFS_CD_OVR, 8'h00);
        cd_in = 1'b1;
        cyc(4);
        chk(cd, 1'b1);
        cd_in = 1'b0;
        cyc(4);
        chk(cd, 1'b0);
        i_host.wr(OFS_PWR_SAVE, 8'h00);
        chk(ps, 1'b0);
        i_host.set_gate(1'b0);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(OFS_OSC_SLOPE, {i[1:0], 6'h00});
            chk({ow, on}, {i == 3, i == 2});
        end
        for (int i = 0; i < 8; i++) begin
            i_host.wr(OFS_TX_GAIN, 8'(i));
            chk(gain, i[2:0]);
            rc(OFS_TX_GAIN, 8'(i));
        end
        // Clock enable low: write must not land
        clk_en = 1'b0;
        i_host.wr(OFS_TX_GAIN, 8'h02);
        chk(gain, 3'h7);
        clk_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            i_host.wr(OFS_XTAL_CLK, {2'h0, 6'h3f >> (2 * i)});
            chk(trim, 6'h3f >> (2 * i));
        end
        chk(roe, 1'b0);
        rv[0] = rco;
        cyc(1);
        chk(rco, !rv[0]);
        i_host.wr(OFS_XTAL_CLK, 8'h7f);
        chk(rco, 1'b0);
        rc(OFS_XTAL_CLK, 8'h7f);
        // Strength: one sample per receive entry
        s_in = 5'h13;
        rx_en = 1'b1;
        cyc(2);
        rdy = 1'b1;
        cyc(5);
        rc(OFS_STRENGTH, 8'h33);
        s_in = 5'h05;
        rdy = 1'b0;
        cyc(3);
        rdy = 1'b1;
        cyc(5);
        rc(OFS_STRENGTH, 8'h33);
        rdy = 1'b0;
        rx_en = 1'b0;
        cyc(4);
        rx_en = 1'b1;
        cyc(2);
        i_host.rd(OFS_STRENGTH, rv);
        chk(rv[5], 1'b0);
        rdy = 1'b1;
        cyc(5);
        rc(OFS_STRENGTH, 8'h25);
        i_host.wr(OFS_STRENGTH, 8'h1f);
        rc(OFS_STRENGTH, 8'h25);
        // Lock wait of 3 steps of 2 cycles
        i_host.wr(OFS_LOCK_DELAY, 8'h03);
        rc(OFS_LOCK_DELAY, 8'h03);
        auto_syn = 1'b1;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(6);
        chk(locked, 1'b0);
        cyc(2);
        chk(locked, 1'b1);
        use_pin = 1'b1;
        cyc(4);
        chk(locked, 1'b0);
        pll = 1'b1;
        cyc(4);
        chk(locked, 1'b1);
        test_done();
    end
endmodule
